/* bom_pkg.sv */
// Constants and types for the power-on and brown-out monitor.
// Assumes a 20 MHz system clock and a slow oscillator near 10 kHz.
package bom_pkg;
    localparam int unsigned ADDR_W = 12;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_PWR = 8'h87;
    localparam logic [7:0] IDX_CTL0 = 8'hA3;
    localparam logic [7:0] IDX_CTL1 = 8'hAB;
    localparam logic [7:0] IDX_CFG = 8'hC0;
    localparam logic [7:0] IDX_UNLK = 8'hC7;
    localparam logic [7:0] IDX_IRQEN = 8'hC8;
    // Field positions
    localparam int PWR_COLD = 4;
    localparam int PWR_DOWN = 1;
    localparam int CFG_EN = 7;
    localparam int CFG_THR = 4;
    localparam int CFG_RSEL = 2;
    localparam int C0_EN = 7;
    localparam int C0_THR = 4;
    localparam int C0_EVT = 3;
    localparam int C0_RSEL = 2;
    localparam int C0_RFLAG = 1;
    localparam int C1_LPS = 1;
    localparam int C1_FLT = 0;
    localparam int IRQ_GLB = 7;
    localparam int IRQ_BO = 2;
    // Unlock keys and reset values
    localparam logic [7:0] KEY_ONE = 8'hAA;
    localparam logic [7:0] KEY_TWO = 8'h55;
    localparam logic [7:0] CTL1_RST = 8'h01;
    localparam logic [7:0] ZERO8 = 8'h00;
    localparam logic [1:0] LPS_NORMAL = 2'h0;
    // Timing
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned LSO_HZ = 10_000;
    localparam int unsigned FAST_FILT_CLKS = 32;
    localparam int unsigned SLOW_FILT_TICKS = 2;
    localparam int unsigned WARM_TICKS = 3;
    localparam int unsigned LP1_US = 1600;
    localparam int unsigned LP2_US = 6400;
    localparam int unsigned LP3_US = 25600;
    localparam int unsigned LP1_TICKS = LP1_US * LSO_HZ / 1_000_000;
    localparam int unsigned LP2_TICKS = LP2_US * LSO_HZ / 1_000_000;
    localparam int unsigned LP3_TICKS = LP3_US * LSO_HZ / 1_000_000;
    localparam int unsigned LP_WIN = SLOW_FILT_TICKS + 1;

    typedef enum logic [2:0] {
        TA_IDLE = 3'b001,
        TA_KEY = 3'b010,
        TA_OPEN = 3'b100
    } bom_ta_t;

    typedef struct packed {
        logic en;
        logic [1:0] thr;
        logic evt;
        logic rsel;
        logic rflag;
    } bom_ctl0_t;
endpackage

/* bom_monitor.sv */
// Power-on flag, brown-out detect control and status behind an APB slave.
// Assumes por_reset comes with sys_rst on a cold start, both on clk.
//
// Our own choice: the APB slave port.
`timescale 1ns/100ps
`default_nettype none

// Contract
// - Power-on reset completion sets the cold start flag.
// - Cold start flag survives non-power-on resets; software clears it.
// - Config threshold field selects trip level, 11 lowest to 00 highest.
// - Runtime threshold field changes trip level with same encoding.
// - Comparator ignored for two to three slow ticks after enable.
// - Drop with reset select 0 sets event flag, requests interrupt.
// - Clearing event flag while still low does not re-set it.
// - Recovery above trip level also sets the event flag.
// - Level status is 1 only when enabled and supply low.
// - Drop with reset select 1 requests a brown-out reset.
// - Brown-out reset sets reset flag; only power-on or software clear.
// - Brown-out control writes need the timed unlock sequence each time; the code puts no time limit on the sequence.
// - Low power sense field powers detector periodically, 1.6/6.4/25.6 ms.
// - Filter on by default; writing 0 bypasses it.
// - Config enable bit switches detector on when 1.
// - Config reset select bit chooses reset on drop when 1.
// - Runtime enable bit switches detector on when 1.
// - Event flag interrupts only with both enables set.
// - Every reset loads enable, threshold, reset select from config.
// - Event flag reset value follows config and supply at reset.
// - Low power sense 00 keeps the detector on continuously.
// - Fast filter needs 32 system clocks in normal fast mode.
// - Otherwise filter needs 2 slow oscillator ticks.
module bom_monitor #(
    parameter logic [7:0] CFG_DEFAULT = 8'h84
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic por_reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [bom_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cmp_below_async,
    input wire logic lso_clk_async,
    input wire logic sys_on_low_speed_osc,
    output logic det_power,
    output logic [1:0] trip_level_sel,
    output logic irq_req,
    output logic brownout_reset_req
);
    function automatic logic is_reg(
        input logic [bom_pkg::ADDR_W-1:0] a,
        input logic [7:0] idx
    );
        is_reg = (a == {2'b00, idx, 2'b00});
    endfunction

    function automatic logic [7:0] lp_last(input logic [1:0] m);
        case (m)
            2'h1: lp_last = 8'(bom_pkg::LP1_TICKS - 1);
            2'h2: lp_last = 8'(bom_pkg::LP2_TICKS - 1);
            default: lp_last = 8'(bom_pkg::LP3_TICKS - 1);
        endcase
    endfunction

    logic [1:0] cmp_sync_reg, lso_sync_reg, warm_reg, lps;
    logic [7:0] pwr_reg, cfg_reg, ctl1_reg, irqen_reg, lp_cnt_reg;
    logic [7:0] rd_mux, wd;
    logic [5:0] filt_cnt_reg;
    bom_pkg::bom_ctl0_t ctl0_reg;
    bom_pkg::bom_ta_t ta_reg, ta_next;
    logic lso_prev_reg, lso_tick, valid, lp_sample, filt_reg, fast_mode;
    logic raw_in, level_reg, level_next, drop, recov;
    logic access, commit, hit, wr, wr_prot;

    // two-stage sync; slow clock is sampled, not used as a clock
    // Runs through reset so the event reset value sees the live supply
    always_ff @(posedge clk)
    begin
        cmp_sync_reg <= {cmp_sync_reg[0], cmp_below_async};
        lso_sync_reg <= {lso_sync_reg[0], lso_clk_async};
        lso_prev_reg <= lso_sync_reg[1];
    end
    assign lso_tick = lso_sync_reg[1] & ~lso_prev_reg;

    // APB: one wait state, answer in second access cycle
    assign access = psel & penable & ~pready;
    assign commit = psel & penable & pready;
    assign hit = is_reg(paddr, bom_pkg::IDX_PWR)
        | is_reg(paddr, bom_pkg::IDX_CTL0)
        | is_reg(paddr, bom_pkg::IDX_CTL1)
        | is_reg(paddr, bom_pkg::IDX_CFG)
        | is_reg(paddr, bom_pkg::IDX_UNLK)
        | is_reg(paddr, bom_pkg::IDX_IRQEN);
    assign wr = commit & pwrite & hit;
    assign wd = pwdata[7:0];
    assign wr_prot = wr & (ta_reg == bom_pkg::TA_OPEN);

    always_comb
    begin
        rd_mux = bom_pkg::ZERO8;
        if (is_reg(paddr, bom_pkg::IDX_PWR))
            rd_mux = pwr_reg;
        else if (is_reg(paddr, bom_pkg::IDX_CTL0))
            rd_mux = {ctl0_reg.en, 1'b0, ctl0_reg.thr, ctl0_reg.evt,
                ctl0_reg.rsel, ctl0_reg.rflag, level_reg};
        else if (is_reg(paddr, bom_pkg::IDX_CTL1))
            rd_mux = ctl1_reg;
        else if (is_reg(paddr, bom_pkg::IDX_CFG))
            rd_mux = cfg_reg;
        else if (is_reg(paddr, bom_pkg::IDX_IRQEN))
            rd_mux = irqen_reg;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= access;
            pslverr <= access & ~hit;
            prdata <= access ? {24'h00_0000, rd_mux} : 32'h0000_0000;
        end
    end

    // Any write to a mapped register other than the expected key drops the sequence
    always_comb
    begin
        ta_next = ta_reg;
        if (wr)
        begin
            case (ta_reg)
                bom_pkg::TA_IDLE:
                    ta_next = (is_reg(paddr, bom_pkg::IDX_UNLK)
                        && wd == bom_pkg::KEY_ONE)
                        ? bom_pkg::TA_KEY : bom_pkg::TA_IDLE;
                bom_pkg::TA_KEY:
                    ta_next = (is_reg(paddr, bom_pkg::IDX_UNLK)
                        && wd == bom_pkg::KEY_TWO)
                        ? bom_pkg::TA_OPEN : bom_pkg::TA_IDLE;
                default: ta_next = bom_pkg::TA_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            ta_reg <= bom_pkg::TA_IDLE;
        else
            ta_reg <= ta_next;
    end

    // Power control: cold start flag survives warm resets
    always_ff @(posedge clk)
    begin
        if (por_reset)
            pwr_reg <= 8'h10;
        else if (sys_rst)
            pwr_reg <= pwr_reg & 8'h10;
        else if (wr && is_reg(paddr, bom_pkg::IDX_PWR))
            pwr_reg <= {wd[7:6], 1'b0, wd[4:0]};
    end

    // Stands in for nonvolatile config; reloaded only at power-on
    always_ff @(posedge clk)
    begin
        if (por_reset)
            cfg_reg <= CFG_DEFAULT;
        else if (wr_prot && is_reg(paddr, bom_pkg::IDX_CFG))
            cfg_reg <= {wd[7], 1'b0, wd[5:2], 2'b00};
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            ctl1_reg <= bom_pkg::CTL1_RST;
        else if (wr_prot && is_reg(paddr, bom_pkg::IDX_CTL1))
            ctl1_reg <= {5'h00, wd[2:0]};
    end
    assign lps = ctl1_reg[bom_pkg::C1_LPS +: 2];

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            irqen_reg <= bom_pkg::ZERO8;
        else if (wr && is_reg(paddr, bom_pkg::IDX_IRQEN))
            irqen_reg <= wd & 8'h84;
    end

    // Control zero; hardware sets win over software clears
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            ctl0_reg.en <= cfg_reg[bom_pkg::CFG_EN];
            ctl0_reg.thr <= cfg_reg[bom_pkg::CFG_THR +: 2];
            ctl0_reg.rsel <= cfg_reg[bom_pkg::CFG_RSEL];
            ctl0_reg.evt <= cfg_reg[bom_pkg::CFG_EN]
                & ~cfg_reg[bom_pkg::CFG_RSEL] & cmp_sync_reg[1];
            ctl0_reg.rflag <= por_reset ? 1'b0 : ctl0_reg.rflag;
        end
        else if (wr_prot && is_reg(paddr, bom_pkg::IDX_CTL0))
        begin
            ctl0_reg.en <= wd[bom_pkg::C0_EN];
            ctl0_reg.thr <= wd[bom_pkg::C0_THR +: 2];
            ctl0_reg.rsel <= wd[bom_pkg::C0_RSEL];
            ctl0_reg.evt <= wd[bom_pkg::C0_EVT] | (drop & ~ctl0_reg.rsel)
                | recov;
            ctl0_reg.rflag <= wd[bom_pkg::C0_RFLAG] | (drop & ctl0_reg.rsel);
        end
        else
        begin
            ctl0_reg.evt <= ctl0_reg.evt | (drop & ~ctl0_reg.rsel) | recov;
            ctl0_reg.rflag <= ctl0_reg.rflag | (drop & ctl0_reg.rsel);
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst || !ctl0_reg.en)
            warm_reg <= 2'h0;
        else if (lso_tick && warm_reg != 2'(bom_pkg::WARM_TICKS))
            warm_reg <= warm_reg + 2'h1;
    end
    assign valid = (warm_reg == 2'(bom_pkg::WARM_TICKS));

    always_ff @(posedge clk)
    begin
        if (sys_rst || lps == bom_pkg::LPS_NORMAL)
            lp_cnt_reg <= bom_pkg::ZERO8;
        else if (lso_tick)
            lp_cnt_reg <= (lp_cnt_reg >= lp_last(lps))
                ? bom_pkg::ZERO8 : lp_cnt_reg + 8'h01;
    end
    assign lp_sample = lso_tick && lp_cnt_reg == lp_last(lps);

    // Powered a few ticks before each sample so the filter can settle
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            // Kept powered in reset so the event reset value is real
            det_power <= cfg_reg[bom_pkg::CFG_EN];
        else
            det_power <= ctl0_reg.en & (lps == bom_pkg::LPS_NORMAL
                | 9'(lp_cnt_reg) + 9'(bom_pkg::LP_WIN)
                > 9'(lp_last(lps)));
    end

    // Comparator is held while unpowered to avoid false edges
    assign raw_in = det_power ? cmp_sync_reg[1] : filt_reg;
    assign fast_mode = ctl1_reg[bom_pkg::C1_FLT]
        & lps == bom_pkg::LPS_NORMAL & ~sys_on_low_speed_osc
        & ~pwr_reg[bom_pkg::PWR_DOWN];

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            filt_reg <= 1'b0;
            filt_cnt_reg <= 6'h00;
        end
        else if (!ctl1_reg[bom_pkg::C1_FLT])
        begin
            filt_reg <= raw_in;
            filt_cnt_reg <= 6'h00;
        end
        else if (raw_in == filt_reg)
            filt_cnt_reg <= 6'h00;
        else if (fast_mode
            && filt_cnt_reg == 6'(bom_pkg::FAST_FILT_CLKS - 1))
        begin
            filt_reg <= raw_in;
            filt_cnt_reg <= 6'h00;
        end
        else if (!fast_mode && lso_tick
            && filt_cnt_reg == 6'(bom_pkg::SLOW_FILT_TICKS - 1))
        begin
            filt_reg <= raw_in;
            filt_cnt_reg <= 6'h00;
        end
        else if (fast_mode || lso_tick)
            filt_cnt_reg <= filt_cnt_reg + 6'h01;
    end

    always_comb
    begin
        level_next = level_reg;
        if (!valid)
            level_next = 1'b0;
        else if (lps == bom_pkg::LPS_NORMAL || lp_sample)
            level_next = filt_reg;
    end
    assign drop = valid & level_next & ~level_reg;
    assign recov = valid & ~level_next & level_reg;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            level_reg <= 1'b0;
            brownout_reset_req <= 1'b0;
            irq_req <= 1'b0;
            trip_level_sel <= cfg_reg[bom_pkg::CFG_THR +: 2];
        end
        else
        begin
            level_reg <= level_next;
            brownout_reset_req <= drop & ctl0_reg.rsel;
            irq_req <= ctl0_reg.evt & irqen_reg[bom_pkg::IRQ_BO]
                & irqen_reg[bom_pkg::IRQ_GLB];
            trip_level_sel <= ctl0_reg.thr;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence drop_seen;
        drop && !ctl0_reg.rsel;
    endsequence

    sequence locked_ctl0_write;
        wr && is_reg(paddr, bom_pkg::IDX_CTL0) && ta_reg != bom_pkg::TA_OPEN;
    endsequence

    cold_flag_set_a: assert property (
        $fell(por_reset) |-> pwr_reg[bom_pkg::PWR_COLD])
        else $error("cold start flag not set after power-on");
    irq_gate_a: assert property (
        (ctl0_reg.evt && irqen_reg[bom_pkg::IRQ_BO]
            && irqen_reg[bom_pkg::IRQ_GLB]) |=> irq_req)
        else $error("interrupt not raised");
    status_off_a: assert property (
        !ctl0_reg.en [*2] |=> !level_reg)
        else $error("status set while detector off");
    warm_up_a: assert property (
        $rose(ctl0_reg.en) |=> !level_reg [*2])
        else $error("status before warm-up");
    event_drop_a: assert property (
        drop_seen |=> ctl0_reg.evt)
        else $error("drop did not set event flag");
    reset_req_a: assert property (
        drop && ctl0_reg.rsel |=> brownout_reset_req
            && ctl0_reg.rflag)
        else $error("drop did not request reset");
    recover_evt_a: assert property (
        recov |=> ctl0_reg.evt)
        else $error("recovery did not set event flag");
    unlock_guard_a: assert property (
        locked_ctl0_write |=> $stable(ctl0_reg.thr)
            && $stable(ctl0_reg.rsel))
        else $error("locked write changed control");
    cfg_load_a: assert property (
        $fell(sys_rst) |-> ctl0_reg.en == cfg_reg[bom_pkg::CFG_EN]
            && ctl0_reg.thr == cfg_reg[bom_pkg::CFG_THR +: 2])
        else $error("runtime bits not loaded from config");
endmodule

`default_nettype wire

/* bom_cmp_model.sv */
// Behavioural supply comparator facing the brown-out monitor.
// Assumes supply_mv is set by the bench in millivolts.
`timescale 1ns/100ps
`default_nettype none
module bom_cmp_model (
    input wire logic det_power,
    input wire logic [1:0] trip_level_sel,
    input wire logic [15:0] supply_mv,
    output logic cmp_below_async
);
    logic junk = 1'b0;
    logic [15:0] trip_mv;
    // Unpowered output is garbage, so it keeps changing
    always #37 junk = ~junk;
    always_comb
        case (trip_level_sel)
            2'h3: trip_mv = 16'd2200;
            2'h2: trip_mv = 16'd2700;
            2'h1: trip_mv = 16'd3700;
            default: trip_mv = 16'd4400;
        endcase
    assign cmp_below_async = det_power ? (supply_mv < trip_mv) : junk;
endmodule
`default_nettype wire

/* testbench.sv */
// Self-checking bench for the brown-out monitor over APB.
// Assumes the comparator model; slow oscillator tick is 40 clocks.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} bom_x_t;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic por_reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic lso_clk_async = 1'b0;
    logic sys_on_low_speed_osc = 1'b0;
    logic [15:0] supply_mv = 16'd3300;
    logic [31:0] prdata;
    logic pready, pslverr, cmp_below_async, det_power, irq_req;
    logic brownout_reset_req;
    logic [1:0] trip_level_sel;
    int err_total = 0;
    int compares = 0;
    int seed = 90182;
    bom_x_t exp_q[$];
    bom_x_t x;

    always #25 clk = ~clk;
    always #1000 lso_clk_async = ~lso_clk_async;

    bom_monitor #(.CFG_DEFAULT(8'hB0)) bom_monitor_inst (.clk, .sys_rst,
        .por_reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .cmp_below_async, .lso_clk_async,
        .sys_on_low_speed_osc, .det_power, .trip_level_sel, .irq_req,
        .brownout_reset_req);
    bom_cmp_model bom_cmp_model_inst (.det_power, .trip_level_sel,
        .supply_mv, .cmp_below_async);

    task automatic close_out();
        $display("compares %0d errors %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want)
        begin
            err_total++;
            $display("[FAIL] %0t seen %h want %h", $time, seen, want);
        end
    endtask

    task automatic ap(input logic w, input logic [7:0] idx,
        input logic [7:0] wd, input logic [7:0] ed, input logic [7:0] em,
        input logic ee);
        int n;
        n = 0;
        exp_q.push_back({{24'h0, ed}, {24'h0, em}, ee});
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {24'h0, wd};
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle edge so the next call never re-drives psel at once
        @(posedge clk);
        if (n >= 20)
        begin
            err_total++;
            close_out();
        end
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] ed,
        input logic [7:0] em);
        ap(1'b0, idx, 8'h00, ed, em, 1'b0);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        ap(1'b1, idx, d, 8'h00, 8'h00, 1'b0);
    endtask

    // Unlock then one protected write
    task automatic tw(input logic [7:0] idx, input logic [7:0] d);
        wr(bom_pkg::IDX_UNLK, bom_pkg::KEY_ONE);
        wr(bom_pkg::IDX_UNLK, bom_pkg::KEY_TWO);
        wr(idx, d);
    endtask

    task automatic det_rise(output int n);
        n = 0;
        while (det_power !== 1'b0 && n < 20000)
        begin
            @(posedge clk);
            n++;
        end
        while (det_power !== 1'b1 && n < 20000)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 20000)
        begin
            err_total++;
            close_out();
        end
    endtask

    function automatic logic [15:0] lvl(input logic [1:0] c);
        return (c == 2'h3) ? 16'd2200 : (c == 2'h2) ? 16'd2700 :
            (c == 2'h1) ? 16'd3700 : 16'd4400;
    endfunction

    // Read data and error are taken at the edge that completes the read
    always @(posedge clk)
        if (psel && penable && pready === 1'b1)
        begin
            x = exp_q.pop_front();
            chk(prdata & x.m, x.d & x.m);
            chk({31'h0, pslverr}, {31'h0, x.e});
        end

    initial
    begin
        int n;
        logic [1:0] c;
        logic [15:0] mv;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        por_reset <= 1'b0;
        @(posedge clk);
        rd(bom_pkg::IDX_PWR, 8'h10, 8'hFF);
        rd(bom_pkg::IDX_CTL0, 8'hB0, 8'hFF);
        rd(bom_pkg::IDX_CTL1, 8'h01, 8'hFF);
        ap(1'b0, 8'h10, 8'h00, 8'h00, 8'hFF, 1'b1);
        chk(det_power, 1'b1);
        chk(trip_level_sel, 2'h3);
        wr(bom_pkg::IDX_CTL0, 8'h00);
        rd(bom_pkg::IDX_CTL0, 8'hB0, 8'hFF);
        tw(bom_pkg::IDX_CTL0, 8'hA0);
        wr(bom_pkg::IDX_CTL0, 8'hB0);
        rd(bom_pkg::IDX_CTL0, 8'hA0, 8'hFF);
        chk(trip_level_sel, 2'h2);
        tw(bom_pkg::IDX_CTL1, 8'h00);
        repeat (200) @(posedge clk);
        // Random supply against every level, filter bypassed
        for (int i = 0; i < 12; i++)
        begin
            c = i[1:0];
            mv = 16'd1900 + 16'($unsigned($random(seed)) % 2800);
            tw(bom_pkg::IDX_CTL0, {2'b10, c, 4'h0});
            supply_mv <= mv;
            repeat (10) @(posedge clk);
            rd(bom_pkg::IDX_CTL0, {2'b10, c, 3'h0, 1'(mv < lvl(c))},
                8'hF5);
        end
        supply_mv <= 16'd3300;
        tw(bom_pkg::IDX_CTL0, 8'hB0);
        tw(bom_pkg::IDX_CTL1, 8'h01);
        repeat (20) @(posedge clk);
        tw(bom_pkg::IDX_CTL0, 8'hB0);
        supply_mv <= 16'd2000;
        repeat (20) @(posedge clk);
        supply_mv <= 16'd3300;
        repeat (50) @(posedge clk);
        rd(bom_pkg::IDX_CTL0, 8'hB0, 8'hFF);
        supply_mv <= 16'd2000;
        repeat (60) @(posedge clk);
        rd(bom_pkg::IDX_CTL0, 8'hB9, 8'hFF);
        for (int i = 0; i < 4; i++)
        begin
            wr(bom_pkg::IDX_IRQEN, {i[1], 4'h0, i[0], 2'h0});
            repeat (3) @(posedge clk);
            chk(irq_req, 1'(i == 3));
        end
        tw(bom_pkg::IDX_CTL0, 8'hB0);
        repeat (60) @(posedge clk);
        rd(bom_pkg::IDX_CTL0, 8'hB1, 8'hFF);
        chk(irq_req, 1'b0);
        supply_mv <= 16'd3300;
        repeat (60) @(posedge clk);
        rd(bom_pkg::IDX_CTL0, 8'hB8, 8'hFF);
        sys_on_low_speed_osc <= 1'b1;
        tw(bom_pkg::IDX_CTL0, 8'hB0);
        supply_mv <= 16'd2000;
        repeat (38) @(posedge clk);
        supply_mv <= 16'd3300;
        repeat (150) @(posedge clk);
        rd(bom_pkg::IDX_CTL0, 8'hB0, 8'hFF);
        sys_on_low_speed_osc <= 1'b0;
        // Power-down alone must also select the slow filter
        wr(bom_pkg::IDX_PWR, 8'h12);
        supply_mv <= 16'd2000;
        repeat (38) @(posedge clk);
        supply_mv <= 16'd3300;
        repeat (150) @(posedge clk);
        rd(bom_pkg::IDX_CTL0, 8'hB0, 8'hFF);
        wr(bom_pkg::IDX_PWR, 8'h10);
        tw(bom_pkg::IDX_CTL1, 8'h00);
        tw(bom_pkg::IDX_CTL0, 8'h30);
        supply_mv <= 16'd2000;
        repeat (10) @(posedge clk);
        chk(det_power, 1'b0);
        rd(bom_pkg::IDX_CTL0, 8'h30, 8'hFF);
        tw(bom_pkg::IDX_CTL0, 8'hB0);
        rd(bom_pkg::IDX_CTL0, 8'h00, 8'h09);
        repeat (250) @(posedge clk);
        rd(bom_pkg::IDX_CTL0, 8'h01, 8'h01);
        supply_mv <= 16'd3300;
        repeat (10) @(posedge clk);
        tw(bom_pkg::IDX_CTL0, 8'hB4);
        supply_mv <= 16'd2000;
        n = 0;
        while (brownout_reset_req !== 1'b1 && n < 30)
        begin
            @(posedge clk);
            n++;
        end
        chk(32'(n < 30), 32'h1);
        sys_rst <= 1'b1;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        rd(bom_pkg::IDX_CTL0, 8'hBA, 8'hFE);
        rd(bom_pkg::IDX_PWR, 8'h10, 8'hFF);
        tw(bom_pkg::IDX_CTL0, 8'hB0);
        rd(bom_pkg::IDX_CTL0, 8'h00, 8'h02);
        tw(bom_pkg::IDX_CTL0, 8'hB2);
        wr(bom_pkg::IDX_PWR, 8'h00);
        sys_rst <= 1'b1;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        rd(bom_pkg::IDX_PWR, 8'h00, 8'hFF);
        sys_rst <= 1'b1;
        por_reset <= 1'b1;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        por_reset <= 1'b0;
        @(posedge clk);
        rd(bom_pkg::IDX_PWR, 8'h10, 8'hFF);
        rd(bom_pkg::IDX_CTL0, 8'h00, 8'h02);
        supply_mv <= 16'd3300;
        // Detector wake period per low power setting
        for (int m = 1; m < 4; m++)
        begin
            tw(bom_pkg::IDX_CTL1, {5'h0, 2'(m), 1'b1});
            det_rise(n);
            det_rise(n);
            n = n - 40 * ((m == 1) ? bom_pkg::LP1_TICKS : (m == 2) ?
                bom_pkg::LP2_TICKS : bom_pkg::LP3_TICKS);
            chk(32'(n > -4 && n < 4), 32'h1);
        end
        tw(bom_pkg::IDX_CTL1, 8'h01);
        repeat (5) @(posedge clk);
        for (int i = 0; i < 100; i++)
        begin
            @(posedge clk);
            if (det_power !== 1'b1)
                n = -1;
        end
        chk(32'(n != -1), 32'h1);
        close_out();
    end
endmodule
`default_nettype wire
